// >>> logic/srx_pkg.sv
// Package of constants and types for the subroutine exit and rotate execution block.
// Assumes a core that runs a four-phase instruction cycle, one phase per clock.
package srx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned INSTR_W     = 16;
  localparam int unsigned ADDR_W_DEF  = 12;
  localparam int unsigned PC_W_DEF    = 21;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned FLAG_W      = 5;

  // ----------------------------------------------------------------
  // Instruction encodings and field positions
  // ----------------------------------------------------------------
  localparam logic [14:0] RET_PATTERN = 15'h0009;
  localparam logic [5:0]  ROT_OPCODE  = 6'h0D;
  localparam int unsigned RET_S_BIT   = 0;
  localparam int unsigned ROT_D_BIT   = 9;
  localparam int unsigned ROT_A_BIT   = 8;
  localparam int unsigned ROT_OP_LSB  = 10;

  // ----------------------------------------------------------------
  // Data memory addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_LIMIT   = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;

  // ----------------------------------------------------------------
  // Flag register layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_C      = 0;
  localparam int unsigned FLAG_DC     = 1;
  localparam int unsigned FLAG_Z      = 2;
  localparam int unsigned FLAG_OV     = 3;
  localparam int unsigned FLAG_N      = 4;
  localparam logic [7:0]  W_RST       = 8'h00;
  localparam logic [4:0]  FLAG_RST    = 5'h00;
  localparam logic [3:0]  BANK_RST    = 4'h0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam int unsigned RET_CYCLES       = 2;
  localparam int unsigned ROT_CYCLES       = 1;

  typedef enum {PH_Q1, PH_Q2, PH_Q3, PH_Q4} srx_phase_type;
  typedef enum {OP_IDLE, OP_RET, OP_RET_NOP, OP_ROT} srx_op_type;

endpackage

// >>> logic/srx_dp_if.sv
// Interface between the execution sequencer and its rotate and addressing datapath.
// Assumes both ends sit in the same clock domain; the datapath is purely combinational.
`timescale 1ns/1ps
interface srx_dp_if #(
  parameter int unsigned ADDR_W = srx_pkg::ADDR_W_DEF
);
  logic [srx_pkg::DATA_W-1:0] rd_data;
  logic                       carry_in;
  logic [srx_pkg::BANK_W-1:0] bank_sel;
  logic [7:0]                 file_addr;
  logic                       acc_sel;
  logic                       ext_en;
  logic [ADDR_W-1:0]          index_base;
  logic [ADDR_W-1:0]          eff_addr;
  logic [srx_pkg::DATA_W-1:0] result;
  logic                       carry_out;
  logic                       neg;
  logic                       zero;

  modport core (
    output rd_data, carry_in, bank_sel, file_addr, acc_sel, ext_en, index_base,
    input  eff_addr, result, carry_out, neg, zero
  );
  modport unit (
    input  rd_data, carry_in, bank_sel, file_addr, acc_sel, ext_en, index_base,
    output eff_addr, result, carry_out, neg, zero
  );
endinterface

// >>> logic/srx_rot_unit.sv
// Rotate-left-through-carry datapath and file register address former.
// Assumes the sequencer registers every output it uses; nothing here holds state.
`timescale 1ns/1ps
module srx_rot_unit #(
  parameter int unsigned ADDR_W = srx_pkg::ADDR_W_DEF
) (
  // Datapath side
  srx_dp_if.unit dp
);

  // ----------------------------------------------------------------
  // Rotate and flags
  // ----------------------------------------------------------------
  // Rotate through carry.
  assign dp.result    = {dp.rd_data[srx_pkg::DATA_W-2:0], dp.carry_in};
  assign dp.carry_out = dp.rd_data[srx_pkg::DATA_W-1];
  assign dp.neg       = dp.result[srx_pkg::DATA_W-1];
  assign dp.zero      = (dp.result == 8'h00);

  // ----------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------
  always_comb begin
    if (dp.acc_sel) begin
      dp.eff_addr = ADDR_W'({dp.bank_sel, dp.file_addr});
    end else if (dp.ext_en && (dp.file_addr <= srx_pkg::IDX_LIMIT)) begin
      dp.eff_addr = dp.index_base + ADDR_W'(dp.file_addr);
    end else if (dp.file_addr < srx_pkg::ACC_SPLIT) begin
      dp.eff_addr = ADDR_W'({srx_pkg::ACC_LO_BANK, dp.file_addr});
    end else begin
      dp.eff_addr = ADDR_W'({srx_pkg::ACC_HI_BANK, dp.file_addr});
    end
  end

endmodule

// >>> logic/srx_exec.sv
// Execution sequencer for the subroutine exit and the rotate-left-through-carry instructions.
// Assumes one phase of the four-phase instruction cycle per clock, a return stack that pops
// on the edge that ends the fourth phase while its pop strobe is high, and a data memory
// that answers a read in the same phase and writes on the edge that ends a write phase.
`timescale 1ns/1ps
module srx_exec #(
  parameter int unsigned ADDR_W = srx_pkg::ADDR_W_DEF,
  parameter int unsigned PC_W   = srx_pkg::PC_W_DEF
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // Instruction stream
  input  wire logic [srx_pkg::INSTR_W-1:0]  instr_word,
  input  wire logic                         instr_valid,
  output logic                              instr_ready_q,
  output logic                              instr_taken_q,
  // Return stack and program counter
  input  wire logic [PC_W-1:0]              stack_top,
  output logic                              stack_pop_q,
  output logic [PC_W-1:0]                   program_counter_q,
  output logic                              pc_load_q,
  // Shadow copies
  input  wire logic [srx_pkg::DATA_W-1:0]   shadow_working_reg,
  input  wire logic [srx_pkg::FLAG_W-1:0]   shadow_flag_reg,
  input  wire logic [srx_pkg::BANK_W-1:0]   shadow_bank_select,
  // Core registers
  output logic [srx_pkg::DATA_W-1:0]        working_reg_q,
  output logic [srx_pkg::FLAG_W-1:0]        flag_reg_q,
  output logic [srx_pkg::BANK_W-1:0]        bank_select_reg_q,
  // Data memory
  output logic [ADDR_W-1:0]                 mem_addr_q,
  output logic                              mem_rd_q,
  input  wire logic [srx_pkg::DATA_W-1:0]   mem_rdata,
  output logic                              mem_wr_q,
  output logic [srx_pkg::DATA_W-1:0]        mem_wdata_q,
  // Addressing configuration
  input  wire logic                         ext_set_en,
  input  wire logic [ADDR_W-1:0]            index_base
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The banked address needs a full bank field above the 8-bit file address.
  if (ADDR_W < 12) begin : g_addr_chk
    $error("srx_exec: ADDR_W must be at least 12");
  end
  if (PC_W < 2) begin : g_pc_chk
    $error("srx_exec: PC_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Exit pattern match.
  function automatic logic is_ret(input logic [srx_pkg::INSTR_W-1:0] w);
    return w[srx_pkg::INSTR_W-1:1] == srx_pkg::RET_PATTERN;
  endfunction

  function automatic logic is_rot(input logic [srx_pkg::INSTR_W-1:0] w);
    return w[srx_pkg::INSTR_W-1:srx_pkg::ROT_OP_LSB] == srx_pkg::ROT_OPCODE;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  srx_pkg::srx_phase_type            phase_q;
  srx_pkg::srx_op_type               op_q;
  srx_pkg::srx_op_type               op_d;
  logic [srx_pkg::INSTR_W-1:0]       ir_q;
  logic [srx_pkg::DATA_W-1:0]        rd_data_q;
  logic [srx_pkg::DATA_W-1:0]        res_q;
  logic                              res_c_q;
  logic                              res_n_q;
  logic                              res_z_q;
  logic                              take;
  logic [srx_pkg::INSTR_W-1:0]       cur_word;

  srx_dp_if #(.ADDR_W(ADDR_W)) dp ();

  srx_rot_unit #(.ADDR_W(ADDR_W)) u_rot (
    .dp (dp.unit)
  );

  // During the first phase the word is still on the input; later it sits in ir_q.
  assign cur_word      = (phase_q == srx_pkg::PH_Q1) ? instr_word : ir_q;
  assign dp.rd_data    = rd_data_q;
  assign dp.carry_in   = flag_reg_q[srx_pkg::FLAG_C];
  assign dp.bank_sel   = bank_select_reg_q;
  assign dp.file_addr  = cur_word[7:0];
  assign dp.acc_sel    = cur_word[srx_pkg::ROT_A_BIT];
  assign dp.ext_en     = ext_set_en;
  assign dp.index_base = index_base;

  // ----------------------------------------------------------------
  // Phase counter and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= srx_pkg::PH_Q1;
    end else begin
      case (phase_q)
        srx_pkg::PH_Q1: phase_q <= srx_pkg::PH_Q2;
        srx_pkg::PH_Q2: phase_q <= srx_pkg::PH_Q3;
        srx_pkg::PH_Q3: phase_q <= srx_pkg::PH_Q4;
        default:        phase_q <= srx_pkg::PH_Q1;
      endcase
    end
  end

  // An exit still in its first cycle blocks the next word, which buys the idle second cycle.
  assign take = (phase_q == srx_pkg::PH_Q1) && instr_valid && (op_q != srx_pkg::OP_RET);

  always_comb begin
    op_d = op_q;
    if (phase_q == srx_pkg::PH_Q1) begin
      if (op_q == srx_pkg::OP_RET) begin
        op_d = srx_pkg::OP_RET_NOP;
      end else if (instr_valid && is_ret(instr_word)) begin
        op_d = srx_pkg::OP_RET;
      end else if (instr_valid && is_rot(instr_word)) begin
        op_d = srx_pkg::OP_ROT;
      end else begin
        op_d = srx_pkg::OP_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_q          <= srx_pkg::OP_IDLE;
      ir_q          <= 16'h0000;
      instr_ready_q <= 1'b1;
      instr_taken_q <= 1'b0;
    end else begin
      op_q          <= op_d;
      instr_ready_q <= (op_d != srx_pkg::OP_RET);
      instr_taken_q <= take;
      if (take) begin
        ir_q <= instr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Subroutine exit
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_pop_q       <= 1'b0;
      pc_load_q         <= 1'b0;
      program_counter_q <= '0;
    end else begin
      // Pop strobe covers the fourth phase.
      stack_pop_q <= (op_q == srx_pkg::OP_RET) && (phase_q == srx_pkg::PH_Q3);
      pc_load_q   <= stack_pop_q;
      // Only the counter is loaded; both latches live outside and see nothing.
      if (stack_pop_q) begin
        program_counter_q <= stack_top;
      end
    end
  end

  // ----------------------------------------------------------------
  // Rotate datapath registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_addr_q  <= '0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
      rd_data_q   <= 8'h00;
      res_q       <= 8'h00;
      res_c_q     <= 1'b0;
      res_n_q     <= 1'b0;
      res_z_q     <= 1'b0;
    end else begin
      mem_rd_q <= take && is_rot(instr_word);
      if (take && is_rot(instr_word)) begin
        mem_addr_q <= dp.eff_addr;
      end
      if ((op_q == srx_pkg::OP_ROT) && (phase_q == srx_pkg::PH_Q2)) begin
        rd_data_q <= mem_rdata;
      end
      // Process in phase three, write strobe covers phase four.
      if ((op_q == srx_pkg::OP_ROT) && (phase_q == srx_pkg::PH_Q3)) begin
        res_q       <= dp.result;
        res_c_q     <= dp.carry_out;
        res_n_q     <= dp.neg;
        res_z_q     <= dp.zero;
        mem_wdata_q <= dp.result;
      end
      mem_wr_q <= (op_q == srx_pkg::OP_ROT) && (phase_q == srx_pkg::PH_Q3)
                  && ir_q[srx_pkg::ROT_D_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Working, flag and bank registers
  // ----------------------------------------------------------------
  // Without the restore bit an exit falls through, so these registers hold.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      working_reg_q     <= srx_pkg::W_RST;
      flag_reg_q        <= srx_pkg::FLAG_RST;
      bank_select_reg_q <= srx_pkg::BANK_RST;
    end else if (stack_pop_q && ir_q[srx_pkg::RET_S_BIT]) begin
      working_reg_q     <= shadow_working_reg;
      flag_reg_q        <= shadow_flag_reg;
      bank_select_reg_q <= shadow_bank_select;
    end else if ((op_q == srx_pkg::OP_ROT) && (phase_q == srx_pkg::PH_Q4)) begin
      if (!ir_q[srx_pkg::ROT_D_BIT]) begin
        working_reg_q <= res_q;
      end
      flag_reg_q[srx_pkg::FLAG_C] <= res_c_q;
      flag_reg_q[srx_pkg::FLAG_N] <= res_n_q;
      flag_reg_q[srx_pkg::FLAG_Z] <= res_z_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic rot_to_file;
  logic restore_sel;
  logic res_msb;
  assign rot_to_file = ir_q[srx_pkg::ROT_D_BIT];
  assign restore_sel = ir_q[srx_pkg::RET_S_BIT];
  assign res_msb     = rd_data_q[srx_pkg::DATA_W-1];

  sequence ret_start;
    take && is_ret(instr_word);
  endsequence
  sequence rot_start;
    take && is_rot(instr_word);
  endsequence
  sequence rot_commit;
    (op_q == srx_pkg::OP_ROT) && (phase_q == srx_pkg::PH_Q4);
  endsequence

  a_exit_decode: assert property (ret_start |=> (op_q == srx_pkg::OP_RET))
    else $error("exit word not decoded as exit");
  a_exit_pop_pc: assert property (stack_pop_q |=> pc_load_q &&
      (program_counter_q == $past(stack_top)))
    else $error("counter not loaded from stack top");
  a_exit_restore: assert property (stack_pop_q && restore_sel |=>
      (working_reg_q == $past(shadow_working_reg)) && (flag_reg_q == $past(shadow_flag_reg))
      && (bank_select_reg_q == $past(shadow_bank_select)))
    else $error("shadow restore missing");
  a_exit_keep_regs: assert property (stack_pop_q && !restore_sel |=>
      $stable(working_reg_q) && $stable(bank_select_reg_q))
    else $error("registers changed without restore");
  a_exit_keep_flags: assert property (stack_pop_q && !restore_sel |=>
      $stable(flag_reg_q))
    else $error("flags changed by exit");
  a_exit_two_cycles: assert property (ret_start |=> !stack_pop_q ##1 !stack_pop_q
      ##1 stack_pop_q ##1 (pc_load_q && !instr_ready_q)
      ##1 (op_q == srx_pkg::OP_RET_NOP)[*4] ##1 (op_q != srx_pkg::OP_RET_NOP))
    else $error("exit cycle sequence wrong");
  a_rot_result: assert property (mem_wr_q |->
      mem_wdata_q == {rd_data_q[srx_pkg::DATA_W-2:0], flag_reg_q[srx_pkg::FLAG_C]})
    else $error("rotate result wrong");
  a_rot_dest_sel: assert property (rot_commit |=>
      (working_reg_q == ($past(rot_to_file) ? $past(working_reg_q) : $past(res_q))))
    else $error("rotate destination wrong");
  a_rot_bank_addr: assert property (mem_rd_q && ir_q[srx_pkg::ROT_A_BIT] |->
      mem_addr_q == ADDR_W'({bank_select_reg_q, ir_q[7:0]}))
    else $error("banked address wrong");
  a_rot_index_addr: assert property (mem_rd_q && !ir_q[srx_pkg::ROT_A_BIT] && ext_set_en
      && (ir_q[7:0] <= srx_pkg::IDX_LIMIT) |-> mem_addr_q == index_base + ADDR_W'(ir_q[7:0]))
    else $error("indexed address wrong");
  a_rot_flags: assert property (rot_commit ##0 (mem_wr_q == rot_to_file) |=>
      (flag_reg_q[srx_pkg::FLAG_C] == $past(res_c_q))
      && (flag_reg_q[srx_pkg::FLAG_N] == $past(res_q[srx_pkg::DATA_W-1]))
      && (flag_reg_q[srx_pkg::FLAG_Z] == ($past(res_q) == 8'h00)))
    else $error("rotate flags wrong");
  a_rot_carry_src: assert property (rot_start |=> ##2
      (res_c_q == res_msb) ##1 (flag_reg_q[srx_pkg::FLAG_C] == $past(res_c_q)))
    else $error("rotate carry not old bit 7");
  a_rot_one_cycle: assert property (rot_start |=> mem_rd_q ##1 !mem_rd_q
      ##1 (mem_wr_q == rot_to_file) ##1 (!mem_wr_q && instr_ready_q))
    else $error("rotate phase timing wrong");

endmodule

// >>> verification/srx_exec_tb_top.sv
// Self-checking testbench for the subroutine exit and rotate execution sequencer.
// Assumes one phase per clock, with the first edge after reset ending phase one.
`timescale 1ns/1ps
module srx_exec_tb_top;
  localparam int unsigned AW = srx_pkg::ADDR_W_DEF;
  localparam int unsigned PW = srx_pkg::PC_W_DEF;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic          ref_clk            = 1'b0;
  logic          rst                = 1'b1;
  logic [15:0]   instr_word         = 16'h0000;
  logic          instr_valid        = 1'b0;
  logic [PW-1:0] stack_top          = '0;
  logic [7:0]    shadow_working_reg = 8'h00;
  logic [4:0]    shadow_flag_reg    = 5'h00;
  logic [3:0]    shadow_bank_select = 4'h0;
  logic [7:0]    mem_rdata          = 8'h00;
  logic          ext_set_en         = 1'b0;
  logic [AW-1:0] index_base         = '0;
  logic          instr_ready_q, instr_taken_q, stack_pop_q, pc_load_q, mem_rd_q, mem_wr_q;
  logic [PW-1:0] program_counter_q;
  logic [7:0]    working_reg_q, mem_wdata_q;
  logic [4:0]    flag_reg_q;
  logic [3:0]    bank_select_reg_q;
  logic [AW-1:0] mem_addr_q;
  logic [7:0]    m_w     = 8'h00;
  logic [4:0]    m_flag  = 5'h00;
  logic [3:0]    m_bank  = 4'h0;
  logic [PW-1:0] m_pc    = '0;
  logic          pend    = 1'b0;
  logic          pwr     = 1'b0;
  logic [7:0]    pwd     = 8'h00;
  logic [31:0]   seed    = 32'h782EB8AB;
  int            bad_count = 0;
  int            checks    = 0;
  int            cycles    = 0;
  logic [24:0]   corners [8] = '{25'h0A50012, 25'h0000013, 25'h180345F, 25'h1003460,
                                 25'h07F365F, 25'h1013712, 25'h0FFF00D, 25'h1803580};

  always #2 ref_clk = ~ref_clk;

  srx_exec dut (
    .ref_clk(ref_clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready_q(instr_ready_q), .instr_taken_q(instr_taken_q), .stack_top(stack_top),
    .stack_pop_q(stack_pop_q), .program_counter_q(program_counter_q), .pc_load_q(pc_load_q),
    .shadow_working_reg(shadow_working_reg), .shadow_flag_reg(shadow_flag_reg),
    .shadow_bank_select(shadow_bank_select), .working_reg_q(working_reg_q),
    .flag_reg_q(flag_reg_q), .bank_select_reg_q(bank_select_reg_q), .mem_addr_q(mem_addr_q),
    .mem_rd_q(mem_rd_q), .mem_rdata(mem_rdata), .mem_wr_q(mem_wr_q),
    .mem_wdata_q(mem_wdata_q), .ext_set_en(ext_set_en), .index_base(index_base)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [AW-1:0] exp_addr(input logic a, input logic [7:0] f);
    if (a) begin
      return AW'({m_bank, f});
    end
    if (ext_set_en && f <= 8'h5F) begin
      return index_base + AW'(f);
    end
    return (f < 8'h60) ? AW'({4'h0, f}) : AW'({4'hF, f});
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The write strobe stands only through the fourth phase, so the check sits inside it.
  task automatic flush();
    @(negedge ref_clk);
    if (pend) begin
      chk(mem_wdata_q, pwd, "rotate result");
      chk(mem_wr_q, pwr, "file write strobe");
    end
    pend = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // One instruction, entered at the edge before its take edge
  // ----------------------------------------------------------------
  task automatic issue(input logic [15:0] w, input logic [7:0] rd, input logic e);
    logic [31:0] q;
    logic [31:0] r;
    logic [7:0]  res;
    q = rnd();
    r = rnd();
    instr_word         <= w;
    instr_valid        <= 1'b1;
    mem_rdata          <= rd;
    ext_set_en         <= e;
    stack_top          <= q[PW-1:0];
    shadow_working_reg <= r[31:24];
    shadow_flag_reg    <= r[4:0];
    shadow_bank_select <= r[8:5];
    index_base         <= r[AW+8:9];
    flush();
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    @(negedge ref_clk);
    chk(instr_taken_q, 32'h1, "taken pulse");
    chk(working_reg_q, m_w, "working reg");
    chk(flag_reg_q, m_flag, "flag reg");
    chk(bank_select_reg_q, m_bank, "bank select");
    chk(program_counter_q, m_pc, "program counter");
    if (w[15:10] == 6'h0D) begin
      chk(mem_rd_q, 32'h1, "read strobe");
      chk(mem_addr_q, exp_addr(w[8], w[7:0]), "file address");
      res = {rd[6:0], m_flag[srx_pkg::FLAG_C]};
      m_flag[srx_pkg::FLAG_C] = rd[7];
      m_flag[srx_pkg::FLAG_N] = res[7];
      m_flag[srx_pkg::FLAG_Z] = (res == 8'h00);
      if (!w[9]) begin
        m_w = res;
      end
      pend = 1'b1;
      pwd  = res;
      pwr  = w[9];
      repeat (2) @(posedge ref_clk);
      flush();
      @(posedge ref_clk);
    end else if (w[15:1] == 15'h0009) begin
      chk(instr_ready_q, 32'h0, "ready during exit");
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(stack_pop_q, 32'h1, "pop strobe");
      @(posedge ref_clk);
      // A rotate held across the first phase of the idle cycle must be refused.
      instr_word  <= {6'h0D, r[11:10], r[23:16]};
      instr_valid <= 1'b1;
      @(negedge ref_clk);
      chk(pc_load_q, 32'h1, "pc load pulse");
      chk(stack_pop_q, 32'h0, "single pop");
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      @(negedge ref_clk);
      chk(program_counter_q, stack_top, "popped pc");
      chk(instr_taken_q, 32'h0, "idle cycle refusal");
      chk(mem_rd_q, 32'h0, "no read in idle");
      chk(instr_ready_q, 32'h1, "ready after exit");
      m_pc = stack_top;
      if (w[0]) begin
        m_w    = shadow_working_reg;
        m_flag = shadow_flag_reg;
        m_bank = shadow_bank_select;
      end
      repeat (3) @(posedge ref_clk);
    end else begin
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(instr_ready_q, 32'h1, "ready in reset");
    chk(program_counter_q, 32'h0, "pc in reset");
    chk(working_reg_q, 32'h0, "working in reset");
    @(posedge ref_clk);
    rst <= 1'b0;
    foreach (corners[i]) begin
      issue(corners[i][15:0], corners[i][23:16], corners[i][24]);
    end
    repeat (200) begin
      r = rnd();
      case (r[2:0])
        3'h0: issue({15'h0009, r[3]}, r[31:24], r[10]);
        3'h1: issue({4'hF, r[15:4]}, r[31:24], r[10]);
        default: issue({6'h0D, r[9:8], r[23:16]}, r[31:24], r[10]);
      endcase
    end
    flush();
    end_of_test();
  end
endmodule
